// >>> bench/ptrp_local_model.sv
// Behavioural model of the local-side target logic.
module ptrp_local_model (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic [1:0] i_mode,
	input wire logic i_disc,
	input wire logic i_local_frame_n,
	input wire logic i_local_transfer_n,
	output logic [63:0] o_local_data,
	output logic o_local_ready_n,
	output logic o_local_disconnect_req_n,
	output int o_total
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [31:0] cnt;
	logic ph;
	logic [63:0] qw;
	// ----------------------------------------
	// Counting, pacing and answers.
	// ----------------------------------------
	always @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt <= 32'h0;
			ph <= 1'b0;
			o_total <= 0;
		end else begin
			ph <= ~ph;
			if (!i_local_transfer_n) begin
				cnt <= cnt + 32'h1;
				o_total <= o_total + 1;
			end else if (i_local_frame_n) begin
				cnt <= 32'h0;
			end
		end
	end
	assign qw = {32'ha0000001 + (cnt << 1), 32'ha0000000 + (cnt << 1)};
	// Every QWORD carries valid data on all bytes; released data shows the inverse.
	assign o_local_data = i_local_frame_n ? ~qw : qw;
	// Mode 0 is prompt, mode 1 every other cycle, mode 2 never ready.
	assign o_local_ready_n = i_local_frame_n | (i_mode == 2'h2) | ((i_mode == 2'h1) & ph);
	// A non-prefetching side asks to disconnect after its first transfer, or at once in modes 2 and 3.
	assign o_local_disconnect_req_n = ~(i_disc & ((cnt != 32'h0) | i_mode[1]));
endmodule

// >>> bench/testbench.sv
// Self-checking bench of the target read path.
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import ptrp_pkg::*;
	localparam logic [31:0] MB = 32'h40000000;
	localparam logic [31:0] IB = 32'h00001200;
	logic clk;
	logic rst;
	ptrp_pci_in_t pci;
	logic [1:0] mode;
	logic disc;
	int tot;
	int err_total;
	int comparisons;
	logic [5:0] cfg_num;
	logic [63:0] ad;
	logic par, devsel_n, trdy_n, stop_n, ack64_n;
	logic lframe_n, lack_n, lxfer_n, ldat_n, hdat_n;
	logic [3:0] lcmd;
	logic [11:0] tsv;
	logic [63:0] ldata;
	logic lrdy_n, ldisc_n;
	logic [63:0] got[$];
	int ph, lat, xf;
	logic fl, fh, lf, st, a64;
	logic ad_oe, ad_hi_oe, ctl_oe;
	logic [2:0] oe;
	logic [31:0] ladr;
	logic [3:0] cm;
	logic [11:0] acc;
	// ----------------------------------------
	// Harness.
	// ----------------------------------------
	ptrp_read_path u_ptrp_read_path (.i_core_clk(clk), .i_rst(rst), .i_pci(pci),
		.i_mem_base(MB[31:12]), .i_io_base(IB[31:8]),
		.i_cfg_rdata({24'hc0f000, 2'h0, cfg_num}), .o_cfg_dword_num(cfg_num),
		.o_ad(ad), .o_ad_oe(ad_oe), .o_ad_hi_oe(ad_hi_oe), .o_par(par),
		.o_par_oe(), .o_par64(), .o_par64_oe(), .o_devsel_n(devsel_n),
		.o_trdy_n(trdy_n), .o_stop_n(stop_n), .o_ack64_n(ack64_n), .o_ctl_oe(ctl_oe),
		.i_local_data(ldata), .i_local_ready_n(lrdy_n),
		.i_local_disconnect_req_n(ldisc_n), .o_local_frame_n(lframe_n),
		.o_local_ack_n(lack_n), .o_local_transfer_n(lxfer_n), .o_ldat_ack_n(ldat_n),
		.o_hdat_ack_n(hdat_n), .o_local_command_out(lcmd), .o_local_addr(ladr),
		.o_target_status_vector(tsv));
	ptrp_local_model u_ptrp_local_model (.i_core_clk(clk), .i_rst(rst), .i_mode(mode),
		.i_disc(disc), .i_local_frame_n(lframe_n), .i_local_transfer_n(lxfer_n),
		.o_local_data(ldata), .o_local_ready_n(lrdy_n),
		.o_local_disconnect_req_n(ldisc_n), .o_total(tot));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task tick;
		@(posedge clk);
		#1;
	endtask
	task chk(input logic [63:0] g, input logic [63:0] e, input string m);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %0t %s: got %h expected %h", $time, m, g, e);
		end
	endtask
	task finish_test;
		$display("Comparisons %0d, mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Master side of one read; the device sees irdy two clocks late, so phases use that view.
	task automatic rd(input logic [3:0] cmd, input logic [31:0] adr, input logic w,
			input int n, input int sp);
		int t, dv, t0, sc, ts;
		logic h1, d, pt, pp;
		logic [31:0] pa;
		got.delete();
		{fl, fh, lf, st, pt, pp, h1} = 7'h1;
		{acc, cm} = 16'h0;
		{ph, lat, sc, ts, dv, t0} = {32'd0, 32'd0, 32'd0, 32'd0, -32'sd1, tot};
		repeat (4) tick;
		pci = '{frame_n: 1'b0, irdy_n: 1'b1, req64_n: ~w, idsel: cmd == CMD_CFG_READ,
			cbe: {4'h0, cmd}, ad: adr};
		tick;
		pci.irdy_n = 1'b0;
		pci.frame_n = n == 1;
		pci.cbe = 8'h0;
		pci.ad = ~adr;
		for (t = 0; t < 120; t++) begin
			tick;
			d = h1;
			h1 = pci.irdy_n;
			if (pp) chk(par, ^pa, "parity");
			pp = 1'b0;
			if (pt && !w) chk(lack_n, 1'b1, "local wait state");
			pt = lxfer_n === 1'b0;
			if (pt && tot == t0) begin
				{fl, fh, cm} = {ldat_n, hdat_n, lcmd};
			end
			if (lframe_n === 1'b0) begin
				lf = 1'b1;
				acc = acc | tsv;
			end
			if (dv < 0 && devsel_n === 1'b0) begin
				dv = t;
				a64 = ack64_n;
				oe = {ad_oe, ad_hi_oe, ctl_oe};
			end
			if (stop_n === 1'b0) begin
				st = 1'b1;
				pci.frame_n = 1'b1;
			end
			if (trdy_n === 1'b0 && d === 1'b0) begin
				if (ph == 0) lat = t - dv;
				got.push_back(ad);
				pa = ad[31:0];
				pp = 1'b1;
				ph++;
				if (ph == n) pci.frame_n = 1'b1;
				if (ph == sp) begin
					sc = 24;
					pci.irdy_n = 1'b1;
				end
			end
			if (sc > 0) begin
				sc--;
				if (sc == 4) ts = tot;
				if (sc == 0) begin
					chk(64'(tot - ts), 64'd0, "full buffer refuses");
					chk(lack_n, 1'b1, "full buffer ack");
					pci.irdy_n = 1'b0;
				end
			end
			if (dv >= 0 && devsel_n === 1'b1) break;
		end
		pci.irdy_n = 1'b1;
		pci.frame_n = 1'b1;
		xf = tot - t0;
		if (t == 120) begin
			chk(1'b1, 1'b0, "timeout");
			finish_test;
		end
	endtask
	// ----------------------------------------
	// Scenarios.
	// ----------------------------------------
	task t_single;
		rd(CMD_MEM_READ, MB, 1'b0, 1, 0);
		chk(64'(ph), 64'd1, "single phases");
		chk(64'(xf), 64'd1, "single fetches");
		chk(64'(lat), 64'd2, "memory latency");
		chk(got[0][31:0], 32'ha0000000, "aligned dword");
		chk({fl, fh}, 2'b00, "aligned acks");
		chk(a64, 1'b1, "ack64 on narrow");
		chk(acc[TSV_WIDE], 1'b0, "narrow width bit");
		chk(lf, 1'b1, "local frame");
		chk(oe, 3'b101, "narrow drivers");
	endtask
	task t_burst;
		rd(CMD_MEM_READ_MULT, MB | 32'h4, 1'b0, 4, 0);
		for (int i = 0; i < 4; i++) chk(got[i][31:0], 32'ha0000001 + i, "dword order");
		chk({fl, fh}, 2'b10, "unaligned acks");
		chk(acc[TSV_BURST], 1'b1, "burst bit");
		chk(acc[TSV_WIDE], 1'b0, "burst width bit");
	endtask
	task t_wide;
		rd(CMD_MEM_READ_LINE, MB, 1'b1, 1, 0);
		chk(got[0], 64'ha0000001_a0000000, "qword");
		chk({a64, acc[TSV_WIDE]}, 2'b01, "wide grant");
		chk(oe, 3'b111, "wide drivers");
	endtask
	task t_io;
		rd(CMD_IO_READ, IB, 1'b0, 1, 0);
		chk(cm, CMD_IO_READ, "io command");
		chk({acc[TSV_BAR1], acc[TSV_BAR0]}, 2'b10, "io bar hit");
		chk(got[0][31:0], 32'ha0000000, "io dword");
		chk(64'(ph), 64'd1, "io phases");
		chk(ladr, IB, "io local address");
	endtask
	task t_cfg;
		mode = 2'h2;
		disc = 1'b1;
		rd(CMD_CFG_READ, 32'h14, 1'b0, 1, 0);
		chk(64'(lat), 64'd1, "config latency");
		chk(got[0][31:0], 32'hc0f00005, "config data");
		chk({lf, st}, 2'b00, "config local and stop");
		mode = 2'h0;
		disc = 1'b0;
	endtask
	task t_disc;
		disc = 1'b1;
		rd(CMD_MEM_READ_MULT, MB, 1'b0, 8, 0);
		chk({st, 64'(xf) == 64'd1}, 2'b11, "disconnect");
		disc = 1'b0;
	endtask
	task t_fifo;
		mode = 2'h1;
		rd(CMD_MEM_READ_MULT, MB, 1'b0, 6, 2);
		for (int i = 0; i < 6; i++) chk(got[i][31:0], 32'ha0000000 + i, "stalled order");
		mode = 2'h0;
	endtask
	initial begin
		rst = 1'b1;
		pci = '{frame_n: 1'b1, irdy_n: 1'b1, req64_n: 1'b1, idsel: 1'b0, cbe: 8'h0, ad: 32'h0};
		{mode, disc} = 3'h0;
		err_total = 0;
		comparisons = 0;
		repeat (20) @(posedge clk);
		#1;
		rst = 1'b0;
		t_single;
		t_burst;
		t_wide;
		t_io;
		t_cfg;
		t_disc;
		t_fifo;
		finish_test;
	end
endmodule

// >>> inc/ptrp_pkg.sv
// Constants, types and carriers of the target read path.
package ptrp_pkg;
	localparam int AD_W = 32;
	localparam int QW_W = 64;
	localparam int FIFO_W = 64;
	localparam int FIFO_D = 8;
	localparam int TSV_W = 12;
	localparam int TSV_BAR0 = 0;
	localparam int TSV_BAR1 = 1;
	localparam int TSV_WIDE = 7;
	localparam int TSV_ACTIVE = 8;
	localparam int TSV_BURST = 9;
	localparam int TSV_XFER = 10;
	localparam int MEM_BASE_LSB = 12;
	localparam int IO_BASE_LSB = 8;
	localparam int QW_HI_BIT = 2;
	localparam logic [3:0] CMD_IO_READ = 4'h2;
	localparam logic [3:0] CMD_MEM_READ = 4'h6;
	localparam logic [3:0] CMD_CFG_READ = 4'ha;
	localparam logic [3:0] CMD_MEM_READ_MULT = 4'hc;
	localparam logic [3:0] CMD_MEM_READ_LINE = 4'he;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_DECODE = 3'b001,
		ST_CLAIM = 3'b010,
		ST_DATA = 3'b011,
		ST_TURN = 3'b100
	} ptrp_state_t;
	typedef struct packed {
		logic frame_n;
		logic irdy_n;
		logic req64_n;
		logic idsel;
		logic [7:0] cbe;
		logic [AD_W-1:0] ad;
	} ptrp_pci_in_t;
	typedef struct packed {
		logic [AD_W-1:0] addr;
		logic [3:0] cmd;
		logic mem_hit;
		logic io_hit;
		logic cfg_hit;
		logic wide;
	} ptrp_addr_t;
endpackage

// >>> rtl/ptrp_read_path.sv
// Target read path: QWORD buffer and PCI/local read sequencing.

// ----------------------------------------
// Buffer between local fetch and PCI data phases.
// ----------------------------------------
module ptrp_fifo #(
	parameter int W = 64,
	parameter int D = 8
) (
	input logic i_core_clk,
	input logic i_rst,
	input logic i_flush,
	input logic i_valid,
	output logic o_ready,
	input logic [W-1:0] i_data,
	output logic o_valid,
	input logic i_ready,
	output logic [W-1:0] o_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW-1:0] wr;
	logic [AW-1:0] rd;
	logic [AW:0] cnt;
	wire push = i_valid && o_ready;
	wire pop = o_valid && i_ready;
	wire [AW-1:0] next_wr = (wr == AW'(D - 1)) ? '0 : wr + 1'b1;
	wire [AW-1:0] next_rd = (rd == AW'(D - 1)) ? '0 : rd + 1'b1;
	assign o_ready = (cnt != (AW + 1)'(D));
	assign o_valid = (cnt != '0);
	assign o_data = mem[rd];
	always_ff @(posedge i_core_clk) begin
		if (push)
			mem[wr] <= i_data;
	end
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			wr <= '0;
			rd <= '0;
			cnt <= '0;
		end else if (i_flush) begin
			wr <= '0;
			rd <= '0;
			cnt <= '0;
		end else begin
			if (push)
				wr <= next_wr;
			if (pop)
				rd <= next_rd;
			cnt <= cnt + (AW + 1)'(push) - (AW + 1)'(pop);
		end
	end
endmodule

// ----------------------------------------
// Read path top.
// ----------------------------------------
module ptrp_read_path (
	input logic i_core_clk,
	input logic i_rst,
	input ptrp_pkg::ptrp_pci_in_t i_pci,
	input logic [ptrp_pkg::AD_W-1:ptrp_pkg::MEM_BASE_LSB] i_mem_base,
	input logic [ptrp_pkg::AD_W-1:ptrp_pkg::IO_BASE_LSB] i_io_base,
	input logic [ptrp_pkg::AD_W-1:0] i_cfg_rdata,
	output logic [5:0] o_cfg_dword_num,
	output logic [ptrp_pkg::QW_W-1:0] o_ad,
	output logic o_ad_oe,
	output logic o_ad_hi_oe,
	output logic o_par,
	output logic o_par_oe,
	output logic o_par64,
	output logic o_par64_oe,
	output logic o_devsel_n,
	output logic o_trdy_n,
	output logic o_stop_n,
	output logic o_ack64_n,
	output logic o_ctl_oe,
	input logic [ptrp_pkg::QW_W-1:0] i_local_data,
	input logic i_local_ready_n,
	input logic i_local_disconnect_req_n,
	output logic o_local_frame_n,
	output logic o_local_ack_n,
	output logic o_local_transfer_n,
	output logic o_ldat_ack_n,
	output logic o_hdat_ack_n,
	output logic [3:0] o_local_command_out,
	output logic [ptrp_pkg::AD_W-1:0] o_local_addr,
	output logic [ptrp_pkg::TSV_W-1:0] o_target_status_vector
);
	import ptrp_pkg::*;

	// ----------------------------------------
	// Pin synchroniser and address capture.
	// ----------------------------------------
	ptrp_pci_in_t pin_meta;
	ptrp_pci_in_t pin;
	logic frame_prev;
	ptrp_addr_t ap;
	ptrp_state_t state;
	logic lframe;
	logic first;
	logic got_one;
	logic burst;
	logic half;
	logic stop_pend;
	logic cfg_done;
	logic xfer_prev;
	logic pci_done_prev;
	logic [TSV_W-1:0] next_tsv;
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			pin_meta <= '1;
			pin <= '1;
			frame_prev <= 1'b1;
		end else begin
			pin_meta <= i_pci;
			pin <= pin_meta;
			frame_prev <= pin.frame_n;
		end
	end
	wire start = (state == ST_IDLE) && !pin.frame_n && frame_prev;
	wire cmd_mem = (pin.cbe[3:0] == CMD_MEM_READ) ||
		(pin.cbe[3:0] == CMD_MEM_READ_MULT) || (pin.cbe[3:0] == CMD_MEM_READ_LINE);
	wire mem_hit = cmd_mem && (pin.ad[AD_W-1:MEM_BASE_LSB] == i_mem_base);
	wire io_hit = (pin.cbe[3:0] == CMD_IO_READ) && (pin.ad[AD_W-1:IO_BASE_LSB] == i_io_base);
	wire cfg_hit = (pin.cbe[3:0] == CMD_CFG_READ) && pin.idsel && (pin.ad[1:0] == 2'b00);
	wire is_cfg = ap.cfg_hit;
	wire claim = ap.mem_hit || ap.io_hit || ap.cfg_hit;

	// ----------------------------------------
	// Local side handshake.
	// ----------------------------------------
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [FIFO_W-1:0] fifo_data;
	wire more_ok = !got_one || burst;
	wire ack = lframe && fifo_in_ready && !xfer_prev && more_ok && !stop_pend;
	wire xfer = ack && !i_local_ready_n;
	wire skip_low = first && ap.addr[QW_HI_BIT] && !ap.wide;
	assign o_local_ack_n = !ack;
	assign o_local_transfer_n = !xfer;
	assign o_ldat_ack_n = !(ack && !skip_low);
	assign o_hdat_ack_n = !ack;
	assign o_local_frame_n = !lframe;

	// ----------------------------------------
	// PCI data phase selection.
	// ----------------------------------------
	wire phase_done = !o_trdy_n && !pin.irdy_n;
	wire last_done = phase_done && pin.frame_n;
	wire have = is_cfg ? !cfg_done : fifo_out_valid;
	wire load_slot = (state == ST_DATA) || ((state == ST_CLAIM) && is_cfg);
	wire load = load_slot && (o_trdy_n || phase_done) && have && !last_done && o_stop_n;
	wire pop = load && !is_cfg && (ap.wide || half);
	wire [AD_W-1:0] dword = half ? fifo_data[QW_W-1:AD_W] : fifo_data[AD_W-1:0];
	wire [QW_W-1:0] next_ad = is_cfg ? {{AD_W{1'b0}}, i_cfg_rdata} :
		(ap.wide ? fifo_data : {{AD_W{1'b0}}, dword});
	wire stop_end = !o_stop_n && pin.frame_n;
	wire finish = (state == ST_DATA) && (last_done || stop_end);
	wire in_txn = (state == ST_DECODE) || (state == ST_CLAIM) || (state == ST_DATA);

	ptrp_fifo #(
		.W(FIFO_W),
		.D(FIFO_D)
	) u_fifo (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_flush(state == ST_TURN),
		.i_valid(xfer),
		.o_ready(fifo_in_ready),
		.i_data(i_local_data),
		.o_valid(fifo_out_valid),
		.i_ready(pop),
		.o_data(fifo_data)
	);

	// ----------------------------------------
	// Sequencer.
	// ----------------------------------------
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			state <= ST_IDLE;
			ap <= '0;
			lframe <= 1'b0;
			first <= 1'b0;
			got_one <= 1'b0;
			burst <= 1'b0;
			half <= 1'b0;
			stop_pend <= 1'b0;
			cfg_done <= 1'b0;
			o_devsel_n <= 1'b1;
			o_trdy_n <= 1'b1;
			o_stop_n <= 1'b1;
			o_ack64_n <= 1'b1;
			o_ctl_oe <= 1'b0;
			o_ad_oe <= 1'b0;
			o_ad_hi_oe <= 1'b0;
			o_ad <= '0;
		end else begin
			case (state)
			ST_IDLE: begin
				if (start) begin
					ap <= '{pin.ad, pin.cbe[3:0], mem_hit, io_hit, cfg_hit,
						mem_hit && !pin.req64_n};
					half <= pin.ad[QW_HI_BIT];
					state <= ST_DECODE;
				end
			end
			ST_DECODE: begin
				if (claim) begin
					o_devsel_n <= 1'b0;
					o_ack64_n <= !ap.wide;
					o_ctl_oe <= 1'b1;
					o_ad_oe <= 1'b1;
					o_ad_hi_oe <= ap.wide;
					lframe <= !ap.cfg_hit;
					first <= 1'b1;
					state <= ST_CLAIM;
				end else
					state <= ST_IDLE;
			end
			ST_CLAIM: state <= ST_DATA;
			ST_DATA: begin
				if (finish) begin
					o_devsel_n <= 1'b1;
					o_ack64_n <= 1'b1;
					o_ad_oe <= 1'b0;
					state <= ST_TURN;
				end
			end
			ST_TURN: begin
				o_ctl_oe <= 1'b0;
				o_ad_hi_oe <= 1'b0;
				lframe <= 1'b0;
				got_one <= 1'b0;
				burst <= 1'b0;
				stop_pend <= 1'b0;
				cfg_done <= 1'b0;
				state <= ST_IDLE;
			end
			default: state <= ST_IDLE;
			endcase
			if (load) begin
				o_ad <= next_ad;
				o_trdy_n <= 1'b0;
				half <= !half;
				cfg_done <= is_cfg;
			end else if (phase_done || finish)
				o_trdy_n <= 1'b1;
			if (xfer) begin
				first <= 1'b0;
				got_one <= 1'b1;
			end
			if (in_txn && !pin.frame_n && !pin.irdy_n)
				burst <= 1'b1;
			if (lframe && !i_local_disconnect_req_n)
				stop_pend <= 1'b1;
			if ((state == ST_DATA) && stop_pend && !finish)
				o_stop_n <= 1'b0;
			else if (finish)
				o_stop_n <= 1'b1;
			if (lframe && pin.frame_n && (got_one || xfer || stop_pend))
				lframe <= 1'b0;
		end
	end

	// ----------------------------------------
	// Parity, status and local address.
	// ----------------------------------------
	always_comb begin
		next_tsv = '0;
		next_tsv[TSV_BAR0] = ap.mem_hit && in_txn;
		next_tsv[TSV_BAR1] = ap.io_hit && in_txn;
		next_tsv[TSV_WIDE] = ap.wide && in_txn;
		next_tsv[TSV_ACTIVE] = in_txn;
		next_tsv[TSV_BURST] = burst;
		next_tsv[TSV_XFER] = pci_done_prev;
	end
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_par <= 1'b0;
			o_par64 <= 1'b0;
			o_par_oe <= 1'b0;
			o_par64_oe <= 1'b0;
			xfer_prev <= 1'b0;
			pci_done_prev <= 1'b0;
			o_target_status_vector <= '0;
			o_local_command_out <= '0;
			o_local_addr <= '0;
			o_cfg_dword_num <= '0;
		end else begin
			o_par <= ^{o_ad[AD_W-1:0], pin.cbe[3:0]};
			o_par64 <= ^{o_ad[QW_W-1:AD_W], pin.cbe[7:4]};
			o_par_oe <= o_ad_oe;
			o_par64_oe <= o_ad_hi_oe;
			xfer_prev <= xfer && !ap.wide;
			pci_done_prev <= phase_done;
			o_target_status_vector <= next_tsv;
			if (state == ST_DECODE) begin
				o_local_command_out <= ap.cmd;
				o_local_addr <= ap.addr;
				o_cfg_dword_num <= ap.addr[7:2];
			end
		end
	end

	// ----------------------------------------
	// Assertions.
	// ----------------------------------------
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_rst);
	sequence s_narrow_xfer;
		!o_local_transfer_n && !ap.wide;
	endsequence
	sequence s_wait_after;
		o_local_ack_n;
	endsequence
	property p_local_wait;
		s_narrow_xfer |=> s_wait_after;
	endproperty
	a_local_wait: assert property (p_local_wait) else $error("no local wait state");
	property p_no_ack64;
		!o_devsel_n && !ap.wide |-> o_ack64_n;
	endproperty
	a_no_ack64: assert property (p_no_ack64) else $error("ack64 in narrow cycle");
	property p_bit7_low;
		!o_local_frame_n && !ap.wide |=> !o_target_status_vector[TSV_WIDE];
	endproperty
	a_bit7_low: assert property (p_bit7_low) else $error("bit 7 set in narrow");
	property p_par_follow;
		o_ad_oe |=> o_par == ^{$past(o_ad[31:0]), $past(pin.cbe[3:0])};
	endproperty
	a_par_follow: assert property (p_par_follow) else $error("parity not from last ad");
	property p_unaligned;
		!o_local_ack_n && first && ap.addr[2] && !ap.wide |-> o_ldat_ack_n && !o_hdat_ack_n;
	endproperty
	a_unaligned: assert property (p_unaligned) else $error("low ack on unaligned start");
	property p_aligned;
		!o_local_ack_n && !ap.addr[2] |-> !o_ldat_ack_n && !o_hdat_ack_n;
	endproperty
	a_aligned: assert property (p_aligned) else $error("aligned acks wrong");
	property p_cfg_quiet;
		ap.cfg_hit && (state == ST_CLAIM) |-> o_local_frame_n [*2];
	endproperty
	a_cfg_quiet: assert property (p_cfg_quiet) else $error("local frame in config");
	property p_cfg_trdy;
		(state == ST_CLAIM) && ap.cfg_hit |=> !o_trdy_n && !o_devsel_n;
	endproperty
	a_cfg_trdy: assert property (p_cfg_trdy) else $error("config trdy late");
	property p_cfg_no_stop;
		ap.cfg_hit && in_txn |-> o_stop_n;
	endproperty
	a_cfg_no_stop: assert property (p_cfg_no_stop) else $error("stop in config");
	property p_burst_bit;
		in_txn && !pin.frame_n && !pin.irdy_n |-> ##2 o_target_status_vector[TSV_BURST];
	endproperty
	a_burst_bit: assert property (p_burst_bit) else $error("burst bit missing");
	property p_single_one;
		got_one && !burst |-> o_local_transfer_n;
	endproperty
	a_single_one: assert property (p_single_one) else $error("extra single fetch");
endmodule
